/* File: shared/smr_pkg.sv */
// constants and carrier types for the stack, multiply-accumulate and rotate executor
package smr_pkg;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [15:0] d;
    logic [15:0] e;
    logic [15:0] ix;
    logic [15:0] iy;
    logic [15:0] iz;
    logic [15:0] k;
    logic [15:0] condition_word;
    logic [3:0]  sk;
    logic [15:0] sp;
    logic [15:0] h;
    logic [15:0] i;
    logic [35:0] am;
  } smr_regs_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        bsel;
    logic [19:0] addr;
    logic [15:0] wdata;
  } smr_mem_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_PUSH  = 4'h1,
    ST_PULL  = 4'h2,
    ST_MPUSH = 4'h3,
    ST_MPULL = 4'h4,
    ST_RPRE  = 4'h5,
    ST_RIT   = 4'h6,
    ST_ROLW  = 4'h7,
    ST_WAIT  = 4'h8
  } smr_state_t;

  // ==========================================================
  // opcodes
  localparam logic [15:0] OP_PUSH_MULTIPLE   = 16'h0034;
  localparam logic [15:0] OP_PULL_MULTIPLE   = 16'h0035;
  localparam logic [15:0] OP_PUSH_MAC_STATE = 16'h27B8;
  localparam logic [15:0] OP_PULL_MAC_STATE = 16'h27B9;
  localparam logic [15:0] OP_PULL_ACCUM_A   = 16'h3709;
  localparam logic [15:0] OP_PULL_ACCUM_B   = 16'h3719;
  localparam logic [15:0] OP_REPEAT_MUL_ACCUMULATE   = 16'h00FB;
  localparam logic [15:0] OP_ROL_X8 = 16'h000C;
  localparam logic [15:0] OP_ROL_Y8 = 16'h001C;
  localparam logic [15:0] OP_ROL_Z8 = 16'h002C;
  localparam logic [15:0] OP_ROL_X  = 16'h170C;
  localparam logic [15:0] OP_ROL_Y  = 16'h171C;
  localparam logic [15:0] OP_ROL_Z  = 16'h172C;
  localparam logic [15:0] OP_ROL_E  = 16'h173C;
  localparam int          OPC_IDX_LSB  = 4;
  localparam int          OPC_LONG_BIT = 8;

  // ==========================================================
  // cycle counts
  localparam logic [4:0] CYC_STACK_BASE = 5'h04;
  localparam logic [4:0] CYC_PER_REG    = 5'h02;
  localparam logic [4:0] CYC_PUSH_MAC_STATE     = 5'h0E;
  localparam logic [4:0] CYC_PULL_MAC_STATE     = 5'h10;
  localparam logic [4:0] CYC_PULAB      = 5'h06;
  localparam logic [4:0] CYC_REPEAT_MUL_ACCUMULATE_BASE  = 5'h06;
  localparam logic [4:0] CYC_REPEAT_MUL_ACCUMULATE_ITER  = 5'h0C;
  localparam logic [4:0] CYC_ROL        = 5'h08;
  localparam logic [4:0] CYC_UNKNOWN    = 5'h01;
  localparam logic [4:0] RSTEP_MAC      = 5'h0B;
  localparam logic [4:0] RSTEP_RDX      = 5'h0A;
  localparam logic [4:0] RSTEP_RDY      = 5'h09;

  // ==========================================================
  // fields, stack steps, capture targets
  localparam logic [7:0]  MASK_USED  = 8'h7F;
  localparam logic [19:0] SP_WORD    = 20'h00002;
  localparam logic [19:0] SP_BYTE    = 20'h00001;
  localparam logic [2:0]  MAC_WORDS  = 3'h5;
  localparam logic [2:0]  REG_LAST   = 3'h6;
  localparam int CCR_MV = 14;
  localparam int CCR_EV = 12;
  localparam int CCR_N  = 11;
  localparam int CCR_Z  = 10;
  localparam int CCR_V  = 9;
  localparam int CCR_C  = 8;
  localparam int CCR_KEEP_W = 4;
  localparam int K_EK = 12;
  localparam int K_XK = 8;
  localparam int K_YK = 4;
  localparam int K_ZK = 0;
  localparam logic [3:0] T_NONE = 4'h0;
  localparam logic [3:0] T_REG0 = 4'h1;
  localparam logic [3:0] T_CCR  = 4'h7;
  localparam logic [3:0] T_A    = 4'h8;
  localparam logic [3:0] T_B    = 4'h9;
  localparam logic [3:0] T_MAC0 = 4'hA;
  localparam logic [3:0] T_ROL  = 4'hF;

endpackage

/* File: rtl/smr_mac.sv */
// signed fractional multiply-accumulate step with overflow detection
`timescale 1ns/100ps
module smr_mac (
  // operands
  input  wire logic [15:0] h,
  input  wire logic [15:0] i,
  input  wire logic [35:0] am,
  // result
  output logic      [35:0] am_nx,
  output logic             mv,
  output logic             ev
);
  // ==========================================================
  // datapath
  logic signed [31:0] prod;
  logic        [35:0] addend;

  always_comb begin
    prod   = $signed(h) * $signed(i);
    // fractional format: double the full product, so minus one squared stays positive
    addend = {{3{prod[31]}}, prod, 1'b0};
    am_nx  = am + addend;
    // same-sign operands giving other-sign sum
    mv     = (am[35] == addend[35]) && (am_nx[35] != am[35]);
    // extension bits in use
    ev     = !((am_nx[35:31] == 5'h00) || (am_nx[35:31] == 5'h1F));
  end
endmodule

/* File: rtl/smr_exec.sv */
// execution unit for stack, multiply-accumulate and rotate instructions
`timescale 1ns/100ps
// Function
// - push_multiple (34, 8-bit mask) takes 4 plus 2 cycles per register and keeps all flags.
// - push_multiple mask bits 0..6 pick acc_pair..condition_word, each stored then the stack drops by 2.
// - push_mac_state (27B8) stores the MAC registers on the stack in 14 cycles, flags kept.
// - pull_accum_a (3709) adds 2 to the stack, loads A from it, subtracts 1, 6 cycles, flags kept.
// - pull_accum_b (3719) adds 2 to the stack, loads B from it, subtracts 1, 6 cycles, flags kept.
// - pull_multiple (35, 8-bit mask) takes 4 plus 2 times (pulled plus one) cycles, raising the stack by 2 per reg.
// - pull_multiple mask bits run in reverse push order, bit 0 restoring condition_word bits 15..4.
// - pull_mac_state (27B9) restores the MAC registers from the stack in 16 cycles, flags kept.
// - repeat_mul_accumulate (FB) loops until count_acc is negative, 6 plus 12 cycles per pass.
// - each pass accumulates the fractional product, steps both indexes, reloads both sources, sets two flags.
// - rotate_left_byte uses the seven documented opcodes, takes 8 cycles and sets N, Z, V and C.
module smr_exec
  import smr_pkg::*;
(
  // clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RESET_N,
  // instruction from decode
  input  wire logic              START,
  input  wire logic [15:0]       OPCODE,
  input  wire logic [15:0]       OPERAND,
  // register preset while idle
  input  wire logic              REG_LOAD,
  input  wire smr_pkg::smr_regs_t REG_IN,
  // status and register view
  output smr_pkg::smr_regs_t     REGS,
  output logic                   BUSY,
  output logic                   DONE,
  // memory port
  output smr_pkg::smr_mem_t      MEM,
  input  wire logic [15:0]       MEM_RDATA
);
  import smr_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [2:0] low_bit(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int b = 6; b >= 0; b--) begin
      if (m[b]) r = 3'(b);
    end
    return r;
  endfunction

  function automatic logic [3:0] ones(input logic [7:0] m);
    logic [3:0] n;
    n = 4'h0;
    for (int b = 0; b < 8; b++) begin
      n = n + {3'h0, m[b]};
    end
    return n;
  endfunction

  function automatic logic [19:0] addr_of(input logic [3:0] bank, input logic [15:0] idx,
                                          input logic [15:0] off);
    return {bank, idx} + {4'h0, off};
  endfunction

  function automatic logic [15:0] reg_val(input smr_regs_t r, input logic [2:0] id);
    case (id)
      3'h0:    return r.d;
      3'h1:    return r.e;
      3'h2:    return r.ix;
      3'h3:    return r.iy;
      3'h4:    return r.iz;
      3'h5:    return r.k;
      default: return r.condition_word;
    endcase
  endfunction

  function automatic logic [15:0] mac_word(input smr_regs_t r, input logic [2:0] w);
    case (w)
      3'h0:    return r.h;
      3'h1:    return r.i;
      3'h2:    return r.am[15:0];
      3'h3:    return r.am[31:16];
      default: return {12'h000, r.am[35:32]};
    endcase
  endfunction

  // ==========================================================
  // state
  smr_state_t  st_q, st_d;
  smr_regs_t   regs_q, regs_d;
  smr_mem_t    mem_q, mem_d;
  logic [4:0]  rem_q, rem_d;
  logic [7:0]  mask_q, mask_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [7:0]  off_q, off_d;
  logic [19:0] ea_q, ea_d;
  logic [3:0]  p1_q, p2_q, tgt_d;
  logic        busy_q, busy_d, done_q, done_d;
  logic [19:0] sksp;
  logic [35:0] am_nx;
  logic        mv, ev;
  logic [2:0]  id;
  logic [7:0]  rot;
  logic [3:0]  bank;
  logic [15:0] base, offs;

  assign sksp = {regs_q.sk, regs_q.sp};

  smr_mac u_mac (
    .h     (regs_q.h),
    .i     (regs_q.i),
    .am    (regs_q.am),
    .am_nx (am_nx),
    .mv    (mv),
    .ev    (ev)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    st_d = st_q; rem_d = rem_q; mask_d = mask_q; cnt_d = cnt_q;
    off_d = off_q; ea_d = ea_q; regs_d = regs_q; busy_d = busy_q;
    mem_d = '0; tgt_d = T_NONE; done_d = 1'b0;
    id = low_bit(mask_q);
    rot = {MEM_RDATA[6:0], regs_q.condition_word[CCR_C]};
    bank = regs_q.k[K_EK +: 4]; base = 16'h0000;
    offs = OPCODE[OPC_LONG_BIT] ? OPERAND : {8'h00, OPERAND[7:0]};
    case (OPCODE[OPC_IDX_LSB +: 2])
      2'h0:    begin bank = regs_q.k[K_XK +: 4]; base = regs_q.ix; end
      2'h1:    begin bank = regs_q.k[K_YK +: 4]; base = regs_q.iy; end
      2'h2:    begin bank = regs_q.k[K_ZK +: 4]; base = regs_q.iz; end
      default: ;
    endcase
    // read returns land two edges after issue
    case (p2_q)
      T_REG0:           regs_d.d  = MEM_RDATA;
      T_REG0 + 4'h1:    regs_d.e  = MEM_RDATA;
      T_REG0 + 4'h2:    regs_d.ix = MEM_RDATA;
      T_REG0 + 4'h3:    regs_d.iy = MEM_RDATA;
      T_REG0 + 4'h4:    regs_d.iz = MEM_RDATA;
      T_REG0 + 4'h5:    regs_d.k  = MEM_RDATA;
      T_CCR:            regs_d.condition_word[15:CCR_KEEP_W] = MEM_RDATA[15:CCR_KEEP_W];
      T_A:              regs_d.d[15:8] = MEM_RDATA[7:0];
      T_B:              regs_d.d[7:0]  = MEM_RDATA[7:0];
      T_MAC0:           regs_d.h  = MEM_RDATA;
      T_MAC0 + 4'h1:    regs_d.i  = MEM_RDATA;
      T_MAC0 + 4'h2:    regs_d.am[15:0]  = MEM_RDATA;
      T_MAC0 + 4'h3:    regs_d.am[31:16] = MEM_RDATA;
      T_MAC0 + 4'h4:    regs_d.am[35:32] = MEM_RDATA[3:0];
      default: ;
    endcase
    if (busy_q) rem_d = rem_q - 5'h01;
    case (st_q)
      ST_IDLE: begin
        if (REG_LOAD) begin
          regs_d = REG_IN;
        end else if (START) begin
          busy_d = 1'b1;
          st_d = ST_WAIT;
          rem_d = CYC_UNKNOWN - 5'h01;
          case (OPCODE)
            OP_PUSH_MULTIPLE: begin
              st_d = ST_PUSH;
              mask_d = OPERAND[7:0] & MASK_USED;
              rem_d = CYC_STACK_BASE + 5'(CYC_PER_REG * ones(OPERAND[7:0] & MASK_USED)) - 5'h01;
            end
            OP_PULL_MULTIPLE: begin
              st_d = ST_PULL;
              mask_d = OPERAND[7:0] & MASK_USED;
              rem_d = CYC_STACK_BASE + 5'(CYC_PER_REG * (ones(OPERAND[7:0] & MASK_USED) + 4'h1))
                      - 5'h01;
            end
            OP_PUSH_MAC_STATE: begin st_d = ST_MPUSH; cnt_d = 3'h0; rem_d = CYC_PUSH_MAC_STATE - 5'h01; end
            OP_PULL_MAC_STATE: begin st_d = ST_MPULL; cnt_d = 3'h0; rem_d = CYC_PULL_MAC_STATE - 5'h01; end
            OP_PULL_ACCUM_A, OP_PULL_ACCUM_B: begin
              // byte sits at the raised pointer, which then settles one lower
              mem_d = '{req: 1'b1, we: 1'b0, bsel: 1'b1, addr: sksp + SP_WORD, wdata: 16'h0000};
              tgt_d = (OPCODE == OP_PULL_ACCUM_A) ? T_A : T_B;
              {regs_d.sk, regs_d.sp} = sksp + SP_WORD - SP_BYTE;
              rem_d = CYC_PULAB - 5'h01;
            end
            OP_REPEAT_MUL_ACCUMULATE: begin st_d = ST_RPRE; off_d = OPERAND[7:0]; rem_d = CYC_REPEAT_MUL_ACCUMULATE_BASE - 5'h01; end
            OP_ROL_X8, OP_ROL_Y8, OP_ROL_Z8, OP_ROL_X, OP_ROL_Y, OP_ROL_Z, OP_ROL_E: begin
              st_d = ST_ROLW;
              ea_d = addr_of(bank, base, offs);
              mem_d = '{req: 1'b1, we: 1'b0, bsel: 1'b1, addr: addr_of(bank, base, offs), wdata: 16'h0000};
              tgt_d = T_ROL;
              rem_d = CYC_ROL - 5'h01;
            end
            default: ;
          endcase
        end
      end
      ST_PUSH: if (mask_q != 8'h00) begin
        mask_d[id] = 1'b0;
        mem_d = '{req: 1'b1, we: 1'b1, bsel: 1'b0, addr: sksp, wdata: reg_val(regs_q, id)};
        {regs_d.sk, regs_d.sp} = sksp - SP_WORD;
      end
      ST_PULL: if (mask_q != 8'h00) begin
        mask_d[id] = 1'b0;
        mem_d = '{req: 1'b1, we: 1'b0, bsel: 1'b0, addr: sksp + SP_WORD, wdata: 16'h0000};
        tgt_d = T_REG0 + {1'b0, REG_LAST - id};
        {regs_d.sk, regs_d.sp} = sksp + SP_WORD;
      end
      ST_MPUSH: if (cnt_q != MAC_WORDS) begin
        mem_d = '{req: 1'b1, we: 1'b1, bsel: 1'b0, addr: sksp, wdata: mac_word(regs_q, cnt_q)};
        {regs_d.sk, regs_d.sp} = sksp - SP_WORD;
        cnt_d = cnt_q + 3'h1;
      end
      ST_MPULL: if (cnt_q != MAC_WORDS) begin
        // last word pushed comes back first
        mem_d = '{req: 1'b1, we: 1'b0, bsel: 1'b0, addr: sksp + SP_WORD, wdata: 16'h0000};
        tgt_d = T_MAC0 + {1'b0, MAC_WORDS - 3'h1 - cnt_q};
        {regs_d.sk, regs_d.sp} = sksp + SP_WORD;
        cnt_d = cnt_q + 3'h1;
      end
      ST_RIT: begin
        if (rem_q == RSTEP_MAC) begin
          regs_d.am = am_nx;
          regs_d.condition_word[CCR_MV] = mv;
          regs_d.condition_word[CCR_EV] = ev;
          // offsets are plain signed nibbles; no modulo masks applied
          regs_d.ix = regs_q.ix + {{12{off_q[7]}}, off_q[7:4]};
          regs_d.iy = regs_q.iy + {{12{off_q[3]}}, off_q[3:0]};
          regs_d.e = regs_q.e - 16'h0001;
        end else if (rem_q == RSTEP_RDX) begin
          mem_d = '{req: 1'b1, we: 1'b0, bsel: 1'b0,
                    addr: addr_of(regs_q.k[K_XK +: 4], regs_q.ix, 16'h0000), wdata: 16'h0000};
          tgt_d = T_MAC0;
        end else if (rem_q == RSTEP_RDY) begin
          mem_d = '{req: 1'b1, we: 1'b0, bsel: 1'b0,
                    addr: addr_of(regs_q.k[K_YK +: 4], regs_q.iy, 16'h0000), wdata: 16'h0000};
          tgt_d = T_MAC0 + 4'h1;
        end
      end
      ST_ROLW: if (p2_q == T_ROL) begin
        mem_d = '{req: 1'b1, we: 1'b1, bsel: 1'b1, addr: ea_q, wdata: {8'h00, rot}};
        regs_d.condition_word[CCR_N] = rot[7];
        regs_d.condition_word[CCR_Z] = (rot == 8'h00);
        regs_d.condition_word[CCR_C] = MEM_RDATA[7];
        regs_d.condition_word[CCR_V] = rot[7] ^ MEM_RDATA[7];
      end
      default: ;
    endcase
    if (busy_q && rem_q == 5'h00) begin
      if (st_q == ST_RPRE || (st_q == ST_RIT && !regs_q.e[15])) begin
        st_d = ST_RIT;
        rem_d = CYC_REPEAT_MUL_ACCUMULATE_ITER - 5'h01;
      end else begin
        st_d = ST_IDLE;
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= ST_IDLE; rem_q <= 5'h00; mask_q <= 8'h00; cnt_q <= 3'h0;
      off_q <= 8'h00; ea_q <= 20'h00000; busy_q <= 1'b0; done_q <= 1'b0;
    end else begin
      st_q <= st_d; rem_q <= rem_d; mask_q <= mask_d; cnt_q <= cnt_d;
      off_q <= off_d; ea_q <= ea_d; busy_q <= busy_d; done_q <= done_d;
    end
  end

  // ==========================================================
  // memory port and read-return pipeline
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mem_q <= '0; p1_q <= T_NONE; p2_q <= T_NONE;
    end else begin
      mem_q <= mem_d; p1_q <= tgt_d; p2_q <= p1_q;
    end
  end

  // ==========================================================
  // programmer-visible registers
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) regs_q <= '0;
    else          regs_q <= regs_d;
  end

  assign REGS = regs_q;
  assign MEM  = mem_q;
  assign BUSY = busy_q;
  assign DONE = done_q;

  // ==========================================================
  // checks
  logic [19:0] cyc_q, sp0_q;
  logic [15:0] op_q;
  logic [3:0]  pc_q;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cyc_q <= 20'h00000; sp0_q <= 20'h00000; op_q <= 16'h0000; pc_q <= 4'h0;
    end else if (st_q == ST_IDLE && START && !REG_LOAD) begin
      cyc_q <= 20'h00000; sp0_q <= sksp; op_q <= OPCODE; pc_q <= ones(OPERAND[7:0] & MASK_USED);
    end else if (busy_q) begin
      cyc_q <= cyc_q + 20'h00001;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_end(logic [15:0] op);
    done_q && op_q == op;
  endsequence
  sequence s_keep(logic [15:0] op);
    busy_q && op_q == op;
  endsequence

  AST_PUSH_MULTIPLE_TIME: assert property (s_end(OP_PUSH_MULTIPLE) |-> cyc_q == CYC_STACK_BASE + CYC_PER_REG * pc_q)
    else $error("push_multiple cycle count wrong");
  AST_PUSH_MULTIPLE_STEP: assert property ((st_q == ST_PUSH && mask_q != 8'h00) |=>
    mem_q.we && mem_q.addr == $past(sksp) && {regs_q.sk, regs_q.sp} == $past(sksp) - SP_WORD)
    else $error("push_multiple store or pointer step wrong");
  AST_PUSH_MAC_STATE: assert property (s_end(OP_PUSH_MAC_STATE) |-> cyc_q == CYC_PUSH_MAC_STATE && sksp == sp0_q - SP_WORD * MAC_WORDS)
    else $error("push_mac_state count or pointer wrong");
  AST_PULL_ACCUM_A: assert property (s_end(OP_PULL_ACCUM_A) |-> cyc_q == CYC_PULAB && sksp == sp0_q + SP_BYTE)
    else $error("pull_accum_a count or pointer wrong");
  AST_PULL_ACCUM_B: assert property (s_end(OP_PULL_ACCUM_B) |-> cyc_q == CYC_PULAB && sksp == sp0_q + SP_BYTE)
    else $error("pull_accum_b count or pointer wrong");
  AST_PULL_MULTIPLE_TIME: assert property (s_end(OP_PULL_MULTIPLE) |->
    cyc_q == CYC_STACK_BASE + CYC_PER_REG * (pc_q + 1) && sksp == sp0_q + SP_WORD * pc_q)
    else $error("pull_multiple count or pointer wrong");
  AST_PULL_MULTIPLE_CCR: assert property ((p2_q == T_CCR) |=> regs_q.condition_word[3:0] == $past(regs_q.condition_word[3:0]))
    else $error("pull_multiple touched low condition bits");
  AST_FLAGS_KEPT: assert property ((s_keep(OP_PUSH_MULTIPLE) or s_keep(OP_PULL_MAC_STATE) or s_keep(OP_PULL_ACCUM_A))
    |=> $stable(regs_q.condition_word))
    else $error("flags changed by a flag-preserving instruction");
  AST_REPEAT_MUL_ACCUMULATE_END: assert property (s_end(OP_REPEAT_MUL_ACCUMULATE) |-> regs_q.e[15] && cyc_q >= CYC_REPEAT_MUL_ACCUMULATE_BASE + CYC_REPEAT_MUL_ACCUMULATE_ITER
    && (cyc_q - CYC_REPEAT_MUL_ACCUMULATE_BASE) % CYC_REPEAT_MUL_ACCUMULATE_ITER == 0)
    else $error("repeat_mul_accumulate ended off a pass boundary");
  AST_REPEAT_MUL_ACCUMULATE_PASS: assert property ((st_q == ST_RIT && rem_q == RSTEP_MAC) |=> regs_q.e == $past(regs_q.e) - 16'h0001
    && regs_q.condition_word[11:0] == $past(regs_q.condition_word[11:0]) ##2 (mem_q.req && !mem_q.we))
    else $error("repeat_mul_accumulate pass misbehaved");
  AST_ROL_TIME: assert property (s_keep(OP_ROL_E) and (rem_q == 5'h00) |=> done_q && cyc_q == CYC_ROL)
    else $error("rotate_left_byte cycle count wrong");
  AST_ROL_DATA: assert property ((st_q == ST_ROLW && p2_q == T_ROL) |=> mem_q.we
    && mem_q.wdata[7:0] == {$past(MEM_RDATA[6:0]), $past(regs_q.condition_word[CCR_C])}
    && regs_q.condition_word[CCR_C] == $past(MEM_RDATA[7]))
    else $error("rotate_left_byte result or carry wrong");
endmodule

/* File: test/smr_exec_test.sv */
// self-checking bench for the stack, multiply-accumulate and rotate executor
`timescale 1ns/100ps
module smr_exec_test;
  import smr_pkg::*;

  // ==========================================================
  // signals
  logic       SYS_CLK;
  logic       RESET_N;
  logic       START;
  logic [15:0] OPCODE;
  logic [15:0] OPERAND;
  logic       REG_LOAD;
  smr_regs_t  REG_IN;
  smr_regs_t  REGS;
  logic       BUSY;
  logic       DONE;
  smr_mem_t   MEM;
  logic [15:0] MEM_RDATA;
  int         n_fail;
  int         checked;
  integer     seed;
  smr_regs_t  ex;
  smr_mem_t   mq;
  logic [7:0] mem[logic [19:0]];
  logic [7:0] em[logic [19:0]];
  logic [15:0] ops[15];

  smr_exec DUT (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .START(START), .OPCODE(OPCODE), .OPERAND(OPERAND),
    .REG_LOAD(REG_LOAD), .REG_IN(REG_IN), .REGS(REGS), .BUSY(BUSY), .DONE(DONE), .MEM(MEM),
    .MEM_RDATA(MEM_RDATA));

  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end

  // ==========================================================
  // memory: untouched bytes read as an address pattern
  function automatic logic [7:0] rdm(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5A;
  endfunction
  function automatic logic [7:0] rde(input logic [19:0] a);
    return em.exists(a) ? em[a] : a[7:0] ^ 8'h5A;
  endfunction
  function automatic logic [15:0] rdw(input logic [19:0] a);
    return {rde(a), rde(a + 20'h00001)};
  endfunction
  function automatic void wrw(input logic [19:0] a, input logic [15:0] w);
    em[a] = w[15:8];
    em[a + 20'h00001] = w[7:0];
  endfunction

  // released data bus toggles every cycle so a stale value never matches
  always @(posedge SYS_CLK) begin
    mq = MEM;
    #1;
    MEM_RDATA = ~MEM_RDATA;
    if (mq.req === 1'b1 && mq.we === 1'b1 && mq.bsel === 1'b1) mem[mq.addr] = mq.wdata[7:0];
    else if (mq.req === 1'b1 && mq.we === 1'b1) begin
      mem[mq.addr] = mq.wdata[15:8];
      mem[mq.addr + 20'h00001] = mq.wdata[7:0];
    end else if (mq.req === 1'b1) MEM_RDATA = mq.bsel ? {~rdm(mq.addr), rdm(mq.addr)}
                                                       : {rdm(mq.addr), rdm(mq.addr + 20'h00001)};
  end

  // ==========================================================
  // reference model: updates ex and em, returns the cycle count
  function automatic logic [15:0] getr(input int k);
    logic [15:0] v[7];
    v = '{ex.d, ex.e, ex.ix, ex.iy, ex.iz, ex.k, ex.condition_word};
    return v[k];
  endfunction
  function automatic void putr(input int k, input logic [15:0] w);
    case (k)
      0: ex.d = w;
      1: ex.e = w;
      2: ex.ix = w;
      3: ex.iy = w;
      4: ex.iz = w;
      5: ex.k = w;
      default: ex.condition_word[15:4] = w[15:4];
    endcase
  endfunction
  function automatic int predict(input logic [15:0] op, input logic [15:0] opd);
    int n;
    logic [15:0] w;
    logic [19:0] a;
    logic [7:0] b;
    logic signed [35:0] p;
    logic [35:0] s;
    n = 0;
    case (op)
      OP_PUSH_MULTIPLE, OP_PULL_MULTIPLE, OP_PUSH_MAC_STATE, OP_PULL_MAC_STATE: begin
        for (int k = 0; k < 7; k++) begin
          if (op == OP_PUSH_MULTIPLE && opd[k]) begin
            wrw({ex.sk, ex.sp}, getr(k));
            ex.sp -= 16'h0002;
            n++;
          end else if (op == OP_PULL_MULTIPLE && opd[k]) begin
            ex.sp += 16'h0002;
            putr(6 - k, rdw({ex.sk, ex.sp}));
            n++;
          end else if (op == OP_PUSH_MAC_STATE && k < 5) begin
            w = k == 0 ? ex.h : k == 1 ? ex.i : k == 2 ? ex.am[15:0] : k == 3 ? ex.am[31:16] : {12'h000, ex.am[35:32]};
            wrw({ex.sk, ex.sp}, w);
            ex.sp -= 16'h0002;
          end else if (op == OP_PULL_MAC_STATE && k < 5) begin
            ex.sp += 16'h0002;
            w = rdw({ex.sk, ex.sp});
            case (k)
              0: ex.am[35:32] = w[3:0];
              1: ex.am[31:16] = w;
              2: ex.am[15:0] = w;
              3: ex.i = w;
              default: ex.h = w;
            endcase
          end
        end
        return op == OP_PUSH_MULTIPLE ? 4 + 2 * n : op == OP_PULL_MULTIPLE ? 4 + 2 * (n + 1) : op == OP_PUSH_MAC_STATE ? 14 : 16;
      end
      OP_PULL_ACCUM_A, OP_PULL_ACCUM_B: begin
        b = rde({ex.sk, ex.sp + 16'h0002});
        if (op == OP_PULL_ACCUM_A) ex.d[15:8] = b;
        else ex.d[7:0] = b;
        ex.sp += 16'h0001;
        return 6;
      end
      OP_REPEAT_MUL_ACCUMULATE: begin
        do begin
          p = $signed({{20{ex.h[15]}}, ex.h}) * $signed({{20{ex.i[15]}}, ex.i});
          p = p <<< 1;
          s = ex.am + p;
          ex.condition_word[CCR_MV] = (ex.am[35] == p[35]) && (s[35] != ex.am[35]);
          ex.condition_word[CCR_EV] = !((&s[35:31]) || !(|s[35:31]));
          ex.am = s;
          ex.ix += {{12{opd[7]}}, opd[7:4]};
          ex.iy += {{12{opd[3]}}, opd[3:0]};
          ex.e -= 16'h0001;
          ex.h = rdw({ex.k[K_XK +: 4], ex.ix});
          ex.i = rdw({ex.k[K_YK +: 4], ex.iy});
          n++;
        end while (!ex.e[15]);
        return 6 + 12 * n;
      end
      OP_ROL_X8, OP_ROL_Y8, OP_ROL_Z8, OP_ROL_X, OP_ROL_Y, OP_ROL_Z, OP_ROL_E: begin
        case (op[5:4])
          2'h0: a = {ex.k[K_XK +: 4], ex.ix} + (op[8] ? {4'h0, opd} : {12'h000, opd[7:0]});
          2'h1: a = {ex.k[K_YK +: 4], ex.iy} + (op[8] ? {4'h0, opd} : {12'h000, opd[7:0]});
          2'h2: a = {ex.k[K_ZK +: 4], ex.iz} + (op[8] ? {4'h0, opd} : {12'h000, opd[7:0]});
          default: a = {ex.k[K_EK +: 4], opd};
        endcase
        b = rde(a);
        em[a] = {b[6:0], ex.condition_word[CCR_C]};
        ex.condition_word[CCR_N] = b[6];
        ex.condition_word[CCR_Z] = {b[6:0], ex.condition_word[CCR_C]} == 8'h00;
        ex.condition_word[CCR_V] = b[6] ^ b[7];
        ex.condition_word[CCR_C] = b[7];
        return 8;
      end
      default: return 1;
    endcase
  endfunction

  // ==========================================================
  // checks and drivers
  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // sp kept mid-range and count_acc small so the stack never wraps and passes stay few
  task automatic preset();
    logic [223:0] v;
    v = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    REG_IN = v[199:0];
    REG_IN.sp[15:12] = 4'h8;
    REG_IN.e = {14'h0000, v[201:200]};
    REG_LOAD = 1'b1;
    @(posedge SYS_CLK);
    #1;
    REG_LOAD = 1'b0;
    ex = REG_IN;
    chk(REGS === ex, "preset not taken");
  endtask

  // poke retries start and preset while busy, both must be ignored
  task automatic exec(input logic [15:0] op, input logic [15:0] opd, input bit poke);
    int cyc;
    int n;
    cyc = predict(op, opd);
    OPCODE = op;
    OPERAND = opd;
    START = 1'b1;
    @(posedge SYS_CLK);
    #1;
    START = 1'b0;
    n = 0;
    chk(BUSY === 1'b1, "busy not raised");
    while (DONE !== 1'b1 && n < 1000) begin
      START = poke && n == 1;
      REG_LOAD = poke && n == 1;
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    START = 1'b0;
    REG_LOAD = 1'b0;
    if (n >= 1000) begin
      n_fail++;
      end_sim();
    end
    chk(n == cyc, "cycle count");
    chk(REGS === ex, "register result");
    foreach (em[k]) chk(rdm(k) === em[k], "memory content");
    foreach (mem[k]) chk(rde(k) === mem[k], "stray memory write");
    @(posedge SYS_CLK);
    #1;
    chk(DONE === 1'b0 && BUSY === 1'b0, "done not a single pulse");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h01ED;
    n_fail = 0;
    checked = 0;
    START = 1'b0;
    OPCODE = 16'h0000;
    OPERAND = 16'h0000;
    REG_LOAD = 1'b0;
    REG_IN = '0;
    MEM_RDATA = 16'hA5C3;
    RESET_N = 1'b0;
    ops = '{OP_PUSH_MULTIPLE, OP_PULL_MULTIPLE, OP_PUSH_MAC_STATE, OP_PULL_MAC_STATE, OP_PULL_ACCUM_A, OP_PULL_ACCUM_B, OP_REPEAT_MUL_ACCUMULATE, OP_ROL_X8, OP_ROL_Y8,
            OP_ROL_Z8, OP_ROL_X, OP_ROL_Y, OP_ROL_Z, OP_ROL_E, 16'h1234};
    repeat (12) @(posedge SYS_CLK);
    #1;
    RESET_N = 1'b1;
    chk(REGS === '0 && BUSY === 1'b0 && MEM.req === 1'b0, "reset state");
    preset();
    exec(OP_PUSH_MULTIPLE, 16'h00FF, 1'b0);
    exec(OP_PUSH_MULTIPLE, 16'h0000, 1'b0);
    exec(OP_PULL_MULTIPLE, 16'h00FF, 1'b0);
    exec(OP_PULL_MULTIPLE, 16'h0001, 1'b0);
    exec(OP_PUSH_MAC_STATE, 16'h0000, 1'b0);
    preset();
    exec(OP_PULL_MAC_STATE, 16'h0000, 1'b0);
    exec(OP_PULL_ACCUM_A, 16'h0000, 1'b1);
    exec(OP_PULL_ACCUM_B, 16'h0000, 1'b0);
    REG_IN = ex;
    REG_IN.e = 16'h0000;
    REG_IN.h = 16'h8000;
    REG_IN.i = 16'h8000;
    REG_LOAD = 1'b1;
    @(posedge SYS_CLK);
    #1;
    REG_LOAD = 1'b0;
    ex = REG_IN;
    exec(OP_REPEAT_MUL_ACCUMULATE, 16'h00F1, 1'b0);
    for (int k = 7; k < 15; k++) exec(ops[k], 16'h00FF, 1'b0);
    for (int r = 0; r < 80; r++) begin
      preset();
      exec(ops[$unsigned($random(seed)) % 15], $random(seed), r[2]);
    end
    end_sim();
  end
endmodule
